//--- logic/aafr_cfg_byte.sv
/*
 * One control byte with its own reset value and a held clear.
 * Assumes the writer has already checked address and permission.
 */
`timescale 1ns/1ps
`default_nettype none
module aafr_cfg_byte #(
   parameter logic [7:0] RST_VAL = 8'h00
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clear,
   input wire logic we,
   input wire logic [7:0] wdata,
   output logic [7:0] q
);
   // ==================================================================
   // Clear is a level: the byte sits at its default while it is held
   always_ff @(posedge clk) begin
      if (!rst_n || clear) begin
         q <= RST_VAL;
      end else if (we) begin
         q <= wdata;
      end
   end
endmodule // aafr_cfg_byte
`default_nettype wire

//--- logic/aafr_edge.sv
/*
 * Edge detector for one sampled pin.
 * Assumes the pin is already synchronous to the core clock.
 */
`timescale 1ns/1ps
`default_nettype none
module aafr_edge #(
   parameter logic IDLE = 1'b1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic pin,
   output logic rise,
   output logic fall
);
   logic prev_q;

   // ==================================================================
   // Previous level, idle level after reset so no false edge
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         prev_q <= IDLE;
      end else begin
         prev_q <= pin;
      end
   end

   // Edges against the previous sample
   assign rise = pin & ~prev_q;
   assign fall = ~pin & prev_q;
endmodule // aafr_edge
`default_nettype wire

//--- logic/aafr_pkg.sv
/*
 * Package of the analog front-end reset controller: register map,
 * reset values, serial frame layout and the carriers shared by files.
 * Assumes one core clock; the controller, checker and bench import it whole.
 */
package aafr_pkg;

   // ==================================================================
   // Register map
   localparam logic [6:0] AAFR_ADDR_CONV_CTRL = 7'h00;
   localparam logic [6:0] AAFR_ADDR_AMP_GAIN = 7'h01;
   localparam logic [6:0] AAFR_ADDR_REG_CTRL = 7'h02;
   localparam logic [6:0] AAFR_ADDR_CONV_REF = 7'h03;
   localparam logic [6:0] AAFR_ADDR_CHAN_PWR = 7'h04;
   localparam logic [6:0] AAFR_ADDR_SELF_RST = 7'h05;
   localparam logic [6:0] AAFR_ADDR_SW_CTRL = 7'h06;
   localparam int AAFR_NUM_REGS = 7;

   // ==================================================================
   // Reset values, index is the register address
   localparam logic [6:0][7:0] AAFR_RST_VALS = {
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80};
   localparam logic [7:0] AAFR_SELF_RST_RST = 8'h00;

   // ==================================================================
   // Field positions
   localparam int AAFR_SELF_RST_BIT = 0;
   localparam int AAFR_PWR_AMP_BIT = 3;
   localparam int AAFR_PWR_CONV_BIT = 2;
   localparam int AAFR_PWR_LDO_BIT = 1;
   localparam int AAFR_PWR_TEMP_BIT = 0;

   // ==================================================================
   // Serial frame: R/W bit, 7 address bits, 8 data bits, MSB first
   localparam int AAFR_FRAME_BITS = 16;
   localparam int AAFR_HDR_BITS = 8;
   localparam int AAFR_RW_POS = 7;
   localparam logic [4:0] AAFR_CNT_LAST = 5'h0F;
   localparam logic [4:0] AAFR_CNT_HDR = 5'h07;
   localparam logic [4:0] AAFR_CNT_FULL = 5'h10;
   localparam logic [4:0] AAFR_CNT_DATA = 5'h08;

   // ==================================================================
   // Carriers
   typedef struct packed {
      logic [7:0] conv_ctrl;
      logic [7:0] amp_gain;
      logic [7:0] reg_ctrl;
      logic [7:0] conv_ref;
      logic [7:0] chan_pwr;
      logic [7:0] sw_ctrl;
   } aafr_regs_t;

   typedef struct packed {
      logic amp;
      logic conv;
      logic temp;
      logic ldo;
   } aafr_run_t;

   typedef struct packed {
      logic temp_pulldown;
      logic ldo_pulldown;
      logic amp_hiz;
      logic conv_hiz;
      logic spi_pullup;
      logic spi_hiz;
   } aafr_pads_t;

endpackage

//--- logic/aafr_reset_ctrl.sv
/*
 * Reset control of the analog front-end with its serial register port.
 * Holds the control bytes, the self-reset bit, the 16-bit serial slave,
 * the run enables of the analog blocks and the pad state controls.
 * Assumes SCLK, CS_N and SDI are sampled in step with CORE_CLK and that
 * SCLK is slow enough for every level to be seen for a cycle or more.
 * Assumes CORE_CLK keeps running while RST_N is low, since the reset is
 * taken on its edges; the minimum low time of RST_N and the pulse after
 * power-up are the host's duty and are not checked here.
 */
`timescale 1ns/1ps
`default_nettype none
module aafr_reset_ctrl
   import aafr_pkg::*;
(
   input wire logic CORE_CLK,
   input wire logic RST_N,
   input wire logic SCLK,
   input wire logic CS_N,
   input wire logic SDI,
   output logic SDO,
   output logic SDO_OE,
   output aafr_regs_t REGS,
   output logic SELF_RESET,
   output aafr_run_t RUN,
   output aafr_pads_t PADS
);

   // ==================================================================
   // Declarations
   // Serial port
   logic sclk_rise;
   logic sclk_fall;
   logic cs_fall;
   logic cs_rise;
   logic [4:0] bit_cnt_q;
   logic [4:0] bit_cnt_d;
   logic [14:0] shift_q;
   logic [15:0] word_d;
   logic rd_mode_q;
   logic [7:0] rd_shift_q;
   logic sdo_q;
   logic sdo_oe_q;
   logic self_rst_q;
   logic wr_frame;
   logic [6:0] wr_addr;
   logic [7:0] wr_data;
   logic [6:0] hdr_addr;
   logic hdr_rw;
   logic [7:0] rd_data;
   logic [7:0] cfg_q [AAFR_NUM_REGS];
   aafr_run_t run_q;
   logic [7:0] chan_pwr;

   // Pad state flip-flops, one per pad group
   logic temp_pd_q;
   logic ldo_pd_q;
   logic amp_hiz_q;
   logic conv_hiz_q;
   logic spi_pullup_q;
   logic spi_hiz_q;

   // ==================================================================
   // Pin edges
   // SCLK idles high between frames, so its first edge is a fall
   aafr_edge #(
      .IDLE(1'b1)
   ) u_sclk_edge (
      .clk(CORE_CLK),
      .rst_n(RST_N),
      .pin(SCLK),
      .rise(sclk_rise),
      .fall(sclk_fall)
   );

   // CS_N idles high too, so holding it high in reset adds no edge
   aafr_edge #(
      .IDLE(1'b1)
   ) u_cs_edge (
      .clk(CORE_CLK),
      .rst_n(RST_N),
      .pin(CS_N),
      .rise(cs_rise),
      .fall(cs_fall)
   );

   // ==================================================================
   // Frame bit counter
   // Saturates at sixteen so stray edges cannot start a second write
   // A frame cut short by CS_N leaves no count behind
   always_comb begin
      bit_cnt_d = bit_cnt_q;
      if (CS_N || cs_fall) begin
         bit_cnt_d = 5'h00;
      end else if (sclk_rise && (bit_cnt_q != AAFR_CNT_FULL)) begin
         bit_cnt_d = bit_cnt_q + 5'h01;
      end
   end

   // Counter is clocked by CORE_CLK only, never by SCLK
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         bit_cnt_q <= 5'h00;
      end else begin
         bit_cnt_q <= bit_cnt_d;
      end
   end

   // ==================================================================
   // Receive shifter
   // Frame: R/W bit first, then seven address bits, then the data,
   // most significant bit first
   // The word as it stands once the current rising edge is taken
   assign word_d = {shift_q, SDI};
   assign hdr_rw = word_d[AAFR_RW_POS];
   assign hdr_addr = word_d[6:0];

   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         shift_q <= 15'h0000;
      end else if (cs_fall) begin
         shift_q <= 15'h0000;
      end else if (!CS_N && sclk_rise && (bit_cnt_q != AAFR_CNT_FULL)) begin
         shift_q <= word_d[14:0];
      end
   end

   // ==================================================================
   // Write decode
   // Only the sixteenth rising edge of a write frame commits
   // Edges past the sixteenth meet a saturated count and do nothing
   assign wr_frame = !CS_N && sclk_rise && (bit_cnt_q == AAFR_CNT_LAST)
                     && word_d[AAFR_FRAME_BITS - 1];
   assign wr_addr = word_d[14:8];
   assign wr_data = word_d[7:0];

   // ==================================================================
   // Self-reset bit
   // Only the low bit is stored; the upper seven have no flip-flops
   // Its own address stays writable while set, so the host can clear it
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         self_rst_q <= AAFR_SELF_RST_RST[AAFR_SELF_RST_BIT];
      end else if (wr_frame && (wr_addr == AAFR_ADDR_SELF_RST)) begin
         // Internal reset never clears this bit, only a write or the reset pin does
         self_rst_q <= wr_data[AAFR_SELF_RST_BIT];
      end
   end

   // ==================================================================
   // Control bytes
   // Held at defaults while self-reset is set, which also drops writes
   // Address 05H has no byte here; it reads the self-reset bit
   for (genvar i = 0; i < AAFR_NUM_REGS; i++) begin : g_cfg
      if (i == int'(AAFR_ADDR_SELF_RST)) begin : g_rc
         assign cfg_q[i] = {7'h00, self_rst_q};
      end else begin : g_byte
         aafr_cfg_byte #(
            .RST_VAL(AAFR_RST_VALS[i])
         ) u_byte (
            .clk(CORE_CLK),
            .rst_n(RST_N),
            .clear(self_rst_q),
            .we(wr_frame && !self_rst_q
                && (wr_addr == 7'(i))),
            .wdata(wr_data),
            .q(cfg_q[i])
         );
      end
   end

   // ==================================================================
   // Read data select
   // Unmapped addresses read as zero
   // The range guard lets the index shrink to the array's three bits
   always_comb begin
      rd_data = 8'h00;
      if (hdr_addr < 7'(AAFR_NUM_REGS)) begin
         rd_data = cfg_q[hdr_addr[2:0]];
      end
   end

   // ==================================================================
   // Read shifter
   // Loaded on the eighth rising edge, once address and R/W are known
   // A write frame never sets read mode, so it never drives SDO
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         rd_mode_q <= 1'b0;
         rd_shift_q <= 8'h00;
      end else if (CS_N) begin
         rd_mode_q <= 1'b0;
      end else if (sclk_rise && (bit_cnt_q == AAFR_CNT_HDR)) begin
         rd_mode_q <= !hdr_rw;
         rd_shift_q <= rd_data;
      end else if (sclk_fall && rd_mode_q && (bit_cnt_q >= AAFR_CNT_DATA)
                   && (bit_cnt_q != AAFR_CNT_FULL)) begin
         rd_shift_q <= {rd_shift_q[6:0], 1'b0};
      end
   end

   // ==================================================================
   // Serial data out
   // Bits leave on falling edges from the ninth one onward
   // CS_N high drops SDO and its enable at once
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         sdo_q <= 1'b0;
         sdo_oe_q <= 1'b0;
      end else if (CS_N) begin
         sdo_q <= 1'b0;
         sdo_oe_q <= 1'b0;
      end else if (sclk_fall && rd_mode_q && (bit_cnt_q >= AAFR_CNT_DATA)
                   && (bit_cnt_q != AAFR_CNT_FULL)) begin
         sdo_q <= rd_shift_q[7];
         sdo_oe_q <= 1'b1;
      end
   end

   // ==================================================================
   // Analog block enables
   // Power byte picked once, with an index of the array's own width
   assign chan_pwr = cfg_q[3'(AAFR_ADDR_CHAN_PWR)];

   // A block runs only if enabled and no reset of either kind is active
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         run_q <= '0;
      end else if (self_rst_q) begin
         run_q <= '0;
      end else begin
         run_q.amp <= chan_pwr[AAFR_PWR_AMP_BIT];
         run_q.conv <= chan_pwr[AAFR_PWR_CONV_BIT];
         run_q.temp <= chan_pwr[AAFR_PWR_TEMP_BIT];
         run_q.ldo <= chan_pwr[AAFR_PWR_LDO_BIT];
      end
   end

   // ==================================================================
   // Pad states
   // Stopped outputs are parked: pull-down or high impedance
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         temp_pd_q <= 1'b1;
         ldo_pd_q <= 1'b1;
         amp_hiz_q <= 1'b1;
         conv_hiz_q <= 1'b1;
      end else begin
         temp_pd_q <= !run_q.temp;
         ldo_pd_q <= !run_q.ldo;
         amp_hiz_q <= !run_q.amp;
         conv_hiz_q <= !run_q.conv;
      end
   end

   // Serial pins: pull-ups from external reset, released by self-reset
   // Clearing self-reset leaves them floating: only the reset pin brings
   // the pull-ups back, so the host must drive every serial line
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         spi_pullup_q <= 1'b1;
         spi_hiz_q <= 1'b0;
      end else if (self_rst_q) begin
         spi_pullup_q <= 1'b0;
         spi_hiz_q <= 1'b1;
      end
   end

   // ==================================================================
   // Outputs, all from flip-flops
   assign SDO = sdo_q;
   assign SDO_OE = sdo_oe_q;
   assign SELF_RESET = self_rst_q;
   assign RUN = run_q;
   assign PADS.temp_pulldown = temp_pd_q;
   assign PADS.ldo_pulldown = ldo_pd_q;
   assign PADS.amp_hiz = amp_hiz_q;
   assign PADS.conv_hiz = conv_hiz_q;
   assign PADS.spi_pullup = spi_pullup_q;
   assign PADS.spi_hiz = spi_hiz_q;

   // Bytes by address; the casts fit the index to the array
   assign REGS.conv_ctrl = cfg_q[3'(AAFR_ADDR_CONV_CTRL)];
   assign REGS.amp_gain = cfg_q[3'(AAFR_ADDR_AMP_GAIN)];
   assign REGS.reg_ctrl = cfg_q[3'(AAFR_ADDR_REG_CTRL)];
   assign REGS.conv_ref = cfg_q[3'(AAFR_ADDR_CONV_REF)];
   assign REGS.chan_pwr = chan_pwr;
   assign REGS.sw_ctrl = cfg_q[3'(AAFR_ADDR_SW_CTRL)];

   // cs_rise is kept for symmetry of the detector; frames end on level
   logic unused_cs_rise;
   assign unused_cs_rise = cs_rise;

endmodule // aafr_reset_ctrl
`default_nettype wire

//--- tb/aafr_host.sv
/* Host model: serial master of the reset controller.
   Assumes the bench calls xfer between core clock edges. */
`timescale 1ns/1ps
`default_nettype none
module aafr_host (
   input wire logic clk,
   output logic sclk,
   output logic cs_n,
   output logic sdi,
   input wire logic sdo
);
   // ====
   // Frame engine
   // Idle: clock parked high, select off
   initial begin
      sclk = 1'b1;
      cs_n = 1'b1;
      sdi = 1'b0;
   end
   // MSB first; n below 16 aborts the frame
   task automatic xfer(input logic [15:0] f, input int n,
      output logic [7:0] rd);
      @(negedge clk) cs_n = 1'b0;
      for (int i = 15; i > 15 - n; i--) begin
         repeat (4) @(negedge clk);
         sclk = 1'b0;
         sdi = f[i];
         repeat (4) @(negedge clk);
         rd = {rd[6:0], sdo}; // Read bit settled before rise
         sclk = 1'b1;
      end
      repeat (4) @(negedge clk);
      cs_n = 1'b1;
      sdi = ~sdi; // Released line must not look held
   endtask
endmodule // aafr_host
`default_nettype wire

//--- tb/aafr_reset_ctrl_asserts.sv
/* Port checker of the reset controller.
   Assumes one core clock and a synchronous low reset. */
`timescale 1ns/1ps
`default_nettype none
module aafr_reset_ctrl_asserts
   import aafr_pkg::*;
(
   input wire logic CORE_CLK,
   input wire logic RST_N,
   input wire logic CS_N,
   input wire logic SDO,
   input wire logic SDO_OE,
   input wire aafr_regs_t REGS,
   input wire logic SELF_RESET,
   input wire aafr_run_t RUN,
   input wire aafr_pads_t PADS
);
   // ====
   // Properties
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);
   // Self-reset seen on two edges in a row
   sequence s_self_on;
      SELF_RESET[*2];
   endsequence
   chk_ext_clear:
   assert property (disable iff (1'b0) !RST_N |=>
      REGS == 48'h800000000000 && !SELF_RESET && RUN == '0
      && PADS.spi_pullup && !PADS.spi_hiz)
      else $error("external reset left state");
   chk_self_dflt:
   assert property (SELF_RESET |=>
      REGS == 48'h800000000000 && RUN == '0)
      else $error("self reset left state");
   chk_self_held:
   assert property (s_self_on |=> $stable(REGS))
      else $error("register changed in self reset");
   chk_pads_map:
   assert property (1'b1 |-> PADS.temp_pulldown == !$past(RUN.temp)
      && PADS.ldo_pulldown == !$past(RUN.ldo)
      && PADS.amp_hiz == !$past(RUN.amp)
      && PADS.conv_hiz == !$past(RUN.conv))
      else $error("pad state off");
   chk_spi_float:
   assert property (SELF_RESET |=> PADS.spi_hiz && !PADS.spi_pullup)
      else $error("serial pads not floating");
   chk_run_src:
   assert property ((!SELF_RESET)[*3] |->
      RUN.amp == $past(REGS.chan_pwr[AAFR_PWR_AMP_BIT])
      && RUN.conv == $past(REGS.chan_pwr[AAFR_PWR_CONV_BIT])
      && RUN.temp == $past(REGS.chan_pwr[AAFR_PWR_TEMP_BIT])
      && RUN.ldo == $past(REGS.chan_pwr[AAFR_PWR_LDO_BIT]))
      else $error("run enable off");
   chk_oe_idle:
   assert property (CS_N[*4] |-> !SDO_OE && !SDO)
      else $error("output driven while idle");
   chk_self_rise:
   assert property ($rose(SELF_RESET) |-> !CS_N)
      else $error("self reset set outside frame");
endmodule // aafr_reset_ctrl_asserts
bind aafr_reset_ctrl aafr_reset_ctrl_asserts u_aafr_reset_ctrl_asserts (
   .CORE_CLK, .RST_N, .CS_N, .SDO, .SDO_OE, .REGS, .SELF_RESET,
   .RUN, .PADS);
`default_nettype wire

//--- tb/testbench.sv
/* Self-checking bench of the reset controller.
   Assumes the host model drives all serial pins. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import aafr_pkg::*;
   logic clk, rst_n, sclk, cs_n, sdi, sdo, sdo_oe, self_rst;
   aafr_regs_t regs;
   aafr_run_t run;
   aafr_pads_t pads;
   int miscompares, num_checks;
   logic [7:0] rd;
   wire sdo_w = sdo_oe ? sdo : 1'b1; // Pulled up when undriven
   aafr_reset_ctrl u_aafr_reset_ctrl (.CORE_CLK(clk), .RST_N(rst_n),
      .SCLK(sclk), .CS_N(cs_n), .SDI(sdi), .SDO(sdo), .SDO_OE(sdo_oe),
      .REGS(regs), .SELF_RESET(self_rst), .RUN(run), .PADS(pads));
   aafr_host u_aafr_host (.clk(clk), .sclk(sclk), .cs_n(cs_n),
      .sdi(sdi), .sdo(sdo_w));
   // ====
   // Clock, tasks
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic cmp(input string nm, input logic [7:0] e, g);
      num_checks++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      u_aafr_host.xfer({1'b1, a, d}, 16, rd);
   endtask
   task automatic rdc(input logic [6:0] a, input logic [7:0] e);
      u_aafr_host.xfer({1'b0, a, 8'h00}, 16, rd);
      cmp($sformatf("reg %h", a), e, rd);
   endtask
   task automatic stop_test;
      if (miscompares == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Hang guard: the tests need under 9k cycles, this waits 30k
   initial begin
      #300000;
      miscompares++;
      stop_test();
   end
   // ====
   // Sequence
   initial begin
      rst_n = 1'b0;
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      for (int a = 0; a < 8; a++)
         rdc(a[6:0], a == 0 ? 8'h80 : 8'h00);
      for (int a = 0; a < 7; a++)
         if (a != 5) wr(a[6:0], 8'h0B + {a[3:0], 4'h0});
      for (int a = 0; a < 7; a++)
         if (a != 5) rdc(a[6:0], 8'h0B + {a[3:0], 4'h0});
      cmp("run", 8'h0B, {4'h0, run});
      cmp("pads", 8'h06, {2'b0, pads});
      u_aafr_host.xfer(16'h8155, 10, rd);
      rdc(7'h01, 8'h1B);
      // Self reset: only its own register stays writable
      wr(7'h05, 8'hFF);
      cmp("self", 8'h01, {7'h0, self_rst});
      rdc(7'h05, 8'h01);
      rdc(7'h00, 8'h80);
      cmp("run", 8'h00, {4'h0, run});
      cmp("pads", 8'h3D, {2'b0, pads});
      wr(7'h01, 8'h77);
      rdc(7'h01, 8'h00);
      wr(7'h05, 8'h00);
      rdc(7'h05, 8'h00);
      wr(7'h01, 8'h77);
      rdc(7'h01, 8'h77);
      // External reset with self reset pending, serial clock still
      wr(7'h05, 8'h01);
      @(negedge clk) rst_n = 1'b0;
      repeat (1000) @(negedge clk);
      cmp("conv", 8'h80, regs.conv_ctrl);
      cmp("self", 8'h00, {7'h0, self_rst});
      rst_n = 1'b1;
      @(negedge clk);
      cmp("pads", 8'h3E, {2'b0, pads});
      rdc(7'h05, 8'h00);
      rdc(7'h01, 8'h00);
      // External reset alone must clear a written byte
      wr(7'h01, 8'h77);
      @(negedge clk) rst_n = 1'b0;
      repeat (1000) @(negedge clk);
      cmp("gain", 8'h00, regs.amp_gain);
      rst_n = 1'b1;
      @(negedge clk);
      rdc(7'h01, 8'h00);
      stop_test();
   end
endmodule // testbench
`default_nettype wire
